/* design/mod_counter.sv */
// Modulo counter stepped by an enable, with synchronous clear
`default_nettype none
module mod_counter #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] modulus,
	output logic      [W-1:0] count,
	output logic              wrap
);
	logic [W-1:0] next_count; // Value for the next edge

	// Terminal state reached on a step; a clear cancels it so a restart sends no stray pulse
	assign wrap = step && !clear && (count == modulus - W'(1));

	// Clear wins, then wrap, then increment
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (wrap) begin
			next_count = '0;
		end else if (step) begin
			next_count = count + W'(1);
		end
	end

	// Plain register, no enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule : mod_counter
`default_nettype wire

/* design/raster_pkg.sv */
// Shared constants and types for the raster timing generator
//
// Summary of operation
// - single width routes column mux to pixel clock
// - double width 80: first dot stage halves
// - double width 132: prescaler becomes divide-by-two
// - load pulse spans the dot beside character clock
// - double width load: halved char clock, delayed
// - fetch pulses follow character clock during hold
// - three fetch pulses before blank falls
// - double width drops alternate fetch pulses, first
// - first horizontal stage divides three or five
// - second horizontal stage divides by seventeen
// - last horizontal stage divides by two
// - drive and blank start at scan end
// - retrace pulse lasts quarter to half scan
// - active scan 83 or 137 characters
// - blank rises on char clock, falls mid-character
// - nine counter bits form unique buffer address
// - second half address has bit 7 low
// - address bits 3,4 serve as keyboard clocks
// - address bit 7 is half-scan square wave
// - interlaced fields odd half-scans, else whole
// - 240 displayed lines, odd field interleaved
// - field start aligned or mid-scan when interlaced
// - mode write decodes columns or refresh rate
// - mode write strobe holds counters cleared
// - dot counter divides by ten or nine
// - prescaler 1.5 for 80, direct for 132
`default_nettype none
package raster_pkg;
	// Register map, byte addresses on APB
	localparam logic [7:0] MODE_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] FIELD_OFFSET  = 8'h08;
	// Mode write data bits
	localparam int MODE_LOW_BIT  = 0;
	localparam int MODE_HIGH_BIT = 1;
	// Master clock rate the dividers run from
	localparam int MASTER_CLK_MHZ = 125;

	// Divider moduli
	localparam logic [1:0] PRESC_DIV_80    = 2'h3;
	localparam logic [1:0] PRESC_DIV_DW132 = 2'h2;
	localparam logic [3:0] DOT_DIV_80      = 4'hA;
	localparam logic [3:0] DOT_DIV_132     = 4'h9;
	localparam logic [2:0] H1_DIV_80       = 3'h3;
	localparam logic [2:0] H1_DIV_132      = 3'h5;
	localparam logic [4:0] H2_DIV          = 5'h11;
	localparam logic [4:0] H2_LAST         = 5'h10;

	// Characters per scan, active characters and retrace width
	localparam logic [7:0] SCAN_80    = 8'h66;
	localparam logic [7:0] SCAN_132   = 8'hAA;
	localparam logic [7:0] ACTIVE_80  = 8'h53;
	localparam logic [7:0] ACTIVE_132 = 8'h89;
	localparam logic [7:0] DRIVE_80   = 8'h22;
	localparam logic [7:0] DRIVE_132  = 8'h38;
	localparam logic [7:0] FETCH_LEAD = 8'h03;

	// Field lengths in half-scans, top offset and display lines
	localparam logic [9:0] FIELD_60_NI = 10'h20C;
	localparam logic [9:0] FIELD_60_IL = 10'h20D;
	localparam logic [9:0] FIELD_50_NI = 10'h276;
	localparam logic [9:0] FIELD_50_IL = 10'h275;
	localparam logic [9:0] TOP_60      = 10'h014;
	localparam logic [9:0] TOP_50      = 10'h032;
	localparam logic [9:0] FIELD_LINES = 10'h0F0;

	// Programmed display mode
	typedef struct packed {
		logic interlace;
		logic hz50;
		logic col132;
	} mode_s;
	localparam mode_s MODE_RESET = '{interlace: 1'b1, hz50: 1'b0, col132: 1'b0};

	// Field parity, one flip per field when interlaced
	typedef enum logic [0:0] {
		FIELD_EVEN = 1'b0,
		FIELD_ODD  = 1'b1
	} field_e;
endpackage : raster_pkg
`default_nettype wire

/* design/video_raster_timing.sv */
// Raster timing generator: dot, character, scan and field timing with APB mode port
`default_nettype none
module video_raster_timing (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 hold_request,
	input  wire logic                 double_width,
	output raster_pkg::mode_s         mode,
	output logic                      pixel_clock,
	output logic                      char_clock,
	output logic                      shift_register_load,
	output logic                      fetch_address_increment,
	output logic                      fetch_increment_window,
	output logic                      horizontal_blank,
	output logic                      horizontal_retrace_pulse_n,
	output logic      [7:0]           line_buffer_addr,
	output logic                      half_scan_tick,
	output logic                      field_start,
	output logic                      odd_field,
	output logic                      field_display
);
	import raster_pkg::*;

	// Address map decode, used for both read and write
	function automatic logic [1:0] reg_index(input logic [7:0] addr);
		if (addr == MODE_OFFSET) begin
			reg_index = 2'h1;
		end else if (addr == STATUS_OFFSET) begin
			reg_index = 2'h2;
		end else if (addr == FIELD_OFFSET) begin
			reg_index = 2'h3;
		end else begin
			reg_index = 2'h0;
		end
	endfunction : reg_index

	// Non-binary line buffer address from the nine horizontal bits
	function automatic logic [7:0] lb_addr(input logic h3, input logic [4:0] h2,
			input logic [2:0] h1);
		if (h2 == H2_LAST) begin
			// Ninth bit folds the last stage-two state into unused low codes
			lb_addr = {~h3, 1'b0, h1, 3'h7};
		end else begin
			lb_addr = {~h3, h2[3:0], h1};
		end
	endfunction : lb_addr

	logic        access;          // APB access phase
	logic        wr_mode;         // Mode write in progress
	logic        mode_write_strobe_n; // Low while a mode write is under way
	logic        clear;           // Counter clear
	mode_s       next_mode;       // Mode after this edge
	logic [31:0] next_prdata;     // Read data captured in setup
	logic [1:0]  presc;           // 1.5 or 2 prescaler state
	logic [1:0]  next_presc;
	logic [1:0]  presc_mod;       // Active prescaler modulus
	logic        dot_en;          // Single-width dot time
	logic        pix_en;          // Selected pixel clock enable
	logic [3:0]  dot_cnt;         // Dot counter state
	logic [3:0]  dot_mod;
	logic        char_en;         // Character clock enable
	logic [2:0]  h1;              // First horizontal stage
	logic [2:0]  h1_mod;
	logic        h1_wrap;
	logic [4:0]  h2;              // Second horizontal stage
	logic        h2_wrap;
	logic        h3;              // Last horizontal stage
	logic        next_h3;
	logic        scan_end;        // Character edge ending a scan
	logic [7:0]  pos;             // Character position in scan
	logic [7:0]  half_len;        // Characters per half-scan
	logic [7:0]  scan_len;
	logic [7:0]  blank_len;
	logic [7:0]  drive_len;
	logic        char_half;       // Every other character clock
	logic        next_char_half;
	logic        fetch_phase;     // Alternating fetch suppressor
	logic        next_fetch_phase;
	logic        window;
	logic        fetch_cand;
	logic [9:0]  half_cnt;        // Half-scans in this field
	logic [9:0]  field_len;
	logic [9:0]  top_len;
	logic [9:0]  line_half;       // Half-scan index aligned to whole scans
	logic        field_wrap;
	field_e      field;
	field_e      next_field;
	logic        next_pixel_clock;
	logic        next_char_clock;
	logic        next_load;
	logic        next_fetch;
	logic        next_window;
	logic        next_blank;
	logic        next_retrace_n;
	logic [7:0]  next_lba;
	logic        next_half_tick;
	logic        next_field_start;
	logic        next_field_display;

	// APB slave: zero wait state, error on unmapped address
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign pslverr = access && (reg_index(paddr) == 2'h0);
	assign wr_mode = access && pwrite && (reg_index(paddr) == 2'h1);
	// The write pulse also clears the timing chain, so writes disturb the display
	assign mode_write_strobe_n = ~wr_mode;
	assign clear = ~mode_write_strobe_n;

	// Mode decode and read data capture
	always_comb begin
		next_mode   = mode;
		next_prdata = prdata;
		if (wr_mode) begin
			if (!pwdata[MODE_HIGH_BIT]) begin
				// Column select forces interlace
				next_mode.col132    = pwdata[MODE_LOW_BIT];
				next_mode.interlace = 1'b1;
			end else begin
				// Refresh select forces noninterlace
				next_mode.hz50      = pwdata[MODE_LOW_BIT];
				next_mode.interlace = 1'b0;
			end
		end
		if (psel && !penable && !pwrite) begin
			// Captured in setup so the access phase returns a flop
			case (reg_index(paddr))
				2'h1: begin
					next_prdata = {29'h0, mode};
				end
				2'h2: begin
					next_prdata = {16'h0, line_buffer_addr, 4'h0, odd_field,
						field_display, horizontal_blank, horizontal_retrace_pulse_n};
				end
				2'h3: begin
					next_prdata = {22'h0, half_cnt};
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Prescaler: 1.5 in 80 columns, 2 in 132 columns where only double width uses it
	always_comb begin
		presc_mod = mode.col132 ? PRESC_DIV_DW132 : PRESC_DIV_80;
		if (clear) begin
			next_presc = 2'h0;
		end else if (presc == presc_mod - 2'h1) begin
			next_presc = 2'h0;
		end else begin
			next_presc = presc + 2'h1;
		end
		// Two enables in three master cycles gives the 1.5 ratio
		dot_en = mode.col132 ? 1'b1 : (presc != 2'h2);
		if (!double_width) begin
			pix_en = dot_en;
		end else if (!mode.col132) begin
			pix_en = dot_en && dot_cnt[0];
		end else begin
			pix_en = (presc == 2'h1);
		end
	end

	// Dot counter sets the character clock
	assign dot_mod = mode.col132 ? DOT_DIV_132 : DOT_DIV_80;
	mod_counter #(.W(4)) u_dot (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (clear),
		.step    (dot_en),
		.modulus (dot_mod),
		.count   (dot_cnt),
		.wrap    (char_en)
	);

	// First stage makes master/45 in both modes
	assign h1_mod = mode.col132 ? H1_DIV_132 : H1_DIV_80;
	mod_counter #(.W(3)) u_h1 (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (clear),
		.step    (char_en),
		.modulus (h1_mod),
		.count   (h1),
		.wrap    (h1_wrap)
	);

	// Second stage, fixed 17, gives the half-scan rate
	mod_counter #(.W(5)) u_h2 (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (clear),
		.step    (h1_wrap),
		.modulus (H2_DIV),
		.count   (h2),
		.wrap    (h2_wrap)
	);

	// Field counter of half-scans; odd length makes fields alternate
	always_comb begin
		if (mode.interlace) begin
			field_len = mode.hz50 ? FIELD_50_IL : FIELD_60_IL;
		end else begin
			field_len = mode.hz50 ? FIELD_50_NI : FIELD_60_NI;
		end
		top_len = mode.hz50 ? TOP_50 : TOP_60;
	end
	mod_counter #(.W(10)) u_field (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (clear),
		.step    (h2_wrap),
		.modulus (field_len),
		.count   (half_cnt),
		.wrap    (field_wrap)
	);

	// Scan geometry for the current column mode
	always_comb begin
		half_len  = mode.col132 ? 8'(H2_DIV) * 8'(H1_DIV_132) : 8'(H2_DIV) * 8'(H1_DIV_80);
		scan_len  = mode.col132 ? SCAN_132 : SCAN_80;
		blank_len = scan_len - (mode.col132 ? ACTIVE_132 : ACTIVE_80);
		drive_len = mode.col132 ? DRIVE_132 : DRIVE_80;
		pos       = (h3 ? half_len : 8'h00) + 8'(h2) * 8'(h1_mod) + 8'(h1);
		scan_end  = h2_wrap && h3;
		window    = (pos >= blank_len - FETCH_LEAD) && (pos < scan_len - FETCH_LEAD);
	end

	// Last stage, phase toggles and field parity
	always_comb begin
		next_h3          = h3;
		next_char_half   = char_half;
		next_fetch_phase = fetch_phase;
		next_field       = field;
		fetch_cand       = char_en && hold_request && window;
		if (clear) begin
			next_h3          = 1'b0;
			next_char_half   = 1'b0;
			next_fetch_phase = 1'b0;
			next_field       = FIELD_EVEN;
		end else begin
			if (h2_wrap) begin
				next_h3 = ~h3;
			end
			if (char_en) begin
				next_char_half = ~char_half;
			end
			if (char_en && pos == blank_len - FETCH_LEAD - 8'h01) begin
				// Restart the suppressor so the first pulse is the one dropped
				next_fetch_phase = 1'b0;
			end else if (fetch_cand) begin
				next_fetch_phase = ~fetch_phase;
			end
			if (field_wrap) begin
				// Noninterlaced fields are all even
				next_field = (mode.interlace && field == FIELD_EVEN) ? FIELD_ODD : FIELD_EVEN;
			end
		end
	end

	// Output decode; all timing outputs leave through flops
	always_comb begin
		next_pixel_clock = pix_en && !clear;
		next_char_clock  = char_en;
		if (clear) begin
			next_load = 1'b0;
		end else if (!double_width) begin
			// Last dot of the character, next to the character clock
			next_load = dot_en && (dot_cnt == dot_mod - 4'h1);
		end else begin
			// Every other character, one single-width dot later
			next_load = dot_en && char_half && (dot_cnt == 4'h0);
		end
		next_fetch  = fetch_cand && (!double_width || fetch_phase);
		next_window = window;
		next_blank  = horizontal_blank;
		if (clear) begin
			next_blank = 1'b1;
		end else if (scan_end) begin
			next_blank = 1'b1;
		end else if (dot_en && pos == blank_len && dot_cnt == (dot_mod >> 1)) begin
			// Mid-character fall; the downstream logic retimes it
			next_blank = 1'b0;
		end
		next_retrace_n = horizontal_retrace_pulse_n;
		if (clear) begin
			next_retrace_n = 1'b1;
		end else if (scan_end) begin
			next_retrace_n = 1'b0;
		end else if (char_en && pos == drive_len - 8'h01) begin
			next_retrace_n = 1'b1;
		end
		next_lba       = lb_addr(h3, h2, h1);
		next_half_tick = h2_wrap;
		// Odd fields begin halfway through a scan by the odd half count
		next_field_start = field_wrap;
		line_half = half_cnt + {9'h000, field == FIELD_ODD};
		next_field_display = (line_half >= (top_len << 1))
			&& (line_half < ((top_len + FIELD_LINES) << 1));
	end

	// State and output registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode                       <= MODE_RESET;
			prdata                     <= 32'h0000_0000;
			presc                      <= 2'h0;
			h3                         <= 1'b0;
			char_half                  <= 1'b0;
			fetch_phase                <= 1'b0;
			field                      <= FIELD_EVEN;
			pixel_clock                <= 1'b0;
			char_clock                 <= 1'b0;
			shift_register_load        <= 1'b0;
			fetch_address_increment    <= 1'b0;
			fetch_increment_window     <= 1'b0;
			horizontal_blank           <= 1'b1;
			horizontal_retrace_pulse_n <= 1'b1;
			line_buffer_addr           <= 8'h80;
			half_scan_tick             <= 1'b0;
			field_start                <= 1'b0;
			odd_field                  <= 1'b0;
			field_display              <= 1'b0;
		end else begin
			mode                       <= next_mode;
			prdata                     <= next_prdata;
			presc                      <= next_presc;
			h3                         <= next_h3;
			char_half                  <= next_char_half;
			fetch_phase                <= next_fetch_phase;
			field                      <= next_field;
			pixel_clock                <= next_pixel_clock;
			char_clock                 <= next_char_clock;
			shift_register_load        <= next_load;
			fetch_address_increment    <= next_fetch;
			fetch_increment_window     <= next_window;
			horizontal_blank           <= next_blank;
			horizontal_retrace_pulse_n <= next_retrace_n;
			line_buffer_addr           <= next_lba;
			half_scan_tick             <= next_half_tick;
			field_start                <= next_field_start;
			odd_field                  <= (next_field == FIELD_ODD);
			field_display              <= next_field_display;
		end
	end
endmodule : video_raster_timing
`default_nettype wire

/* testbench/scan_partner.sv */
// Far-side model: control chip and shift register, counting each scan
`default_nettype none
module scan_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        dma_on,
	input  wire logic        dw_on,
	input  wire logic        char_clock,
	input  wire logic        pixel_clock,
	input  wire logic        shift_register_load,
	input  wire logic        fetch_address_increment,
	input  wire logic        horizontal_blank,
	output logic             hold_request,
	output logic             double_width,
	output logic             display_enable,
	output logic             scan_done,
	output logic [4:0][10:0] scan_stats
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0][10:0] run;        // Counts of the scan in progress
	logic [4:0]       inc;        // Events seen this cycle
	logic             prev_blank; // Blank one cycle back
	logic             edge_up;    // Blank rose: a scan ended
	assign edge_up = horizontal_blank && !prev_blank;
	// Each load pulse is one parallel load of the register
	assign inc = {fetch_address_increment && horizontal_blank,
		shift_register_load, pixel_clock, char_clock, 1'b1};
	// Counting, plus line controls that change only at boundaries
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run, scan_stats, scan_done} <= '0;
			{hold_request, double_width, display_enable} <= '0;
			prev_blank <= 1'b1;
		end else begin
			prev_blank <= horizontal_blank;
			scan_done <= edge_up;
			for (int i = 0; i < 5; i++) begin
				run[i] <= (edge_up ? 11'h000 : run[i]) + {10'h000, inc[i]};
			end
			// Width switches between lines, never mid-line
			if (edge_up) begin
				scan_stats <= run;
				double_width <= dw_on;
			end
			// Video starts on a character boundary, not mid-character
			if (char_clock) begin
				hold_request <= dma_on;
				display_enable <= !horizontal_blank;
			end
		end
	end
endmodule : scan_partner
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the raster timing generator
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import raster_pkg::*;
	logic             pclk, presetn, psel, penable, pwrite; // Clock, reset, bus
	logic [7:0]       paddr;          // Bus address
	logic [31:0]      pwdata, prdata; // Bus data
	logic             pready, pslverr;
	logic             hold_request, double_width;
	mode_s            mode;
	logic             pixel_clock, char_clock, shift_register_load;
	logic             fetch_address_increment, fetch_increment_window;
	logic             horizontal_blank, horizontal_retrace_pulse_n;
	logic [7:0]       line_buffer_addr;
	logic             half_scan_tick, field_start, odd_field, field_display;
	logic             dma_on, dw_on, display_enable, scan_done; // Partner side
	logic [4:0][10:0] scan_stats;     // Counts of the last scan
	int               fails, checks;
	int               chars;          // Expected characters per scan
	logic [31:0]      rd;             // Last read data
	logic             err;            // Last error response
	logic [2:0]       exp_mode;       // Expected mode readback
	logic [1:0]       code;           // Mode code being written
	video_raster_timing dut (.*);
	scan_partner partner (.*);
	// Free-running 125 MHz clock
	always #4 pclk = ~pclk;
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Verdict and stop
	task automatic end_of_test;
		if (fails == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// One bus transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			fails++;
			end_of_test();
		end
	endtask : apb
	// Wait for whole scans, each under a bound
	task automatic scans(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				@(posedge pclk);
				k++;
			end while (scan_done !== 1'b1 && k < 4000);
			if (k >= 4000) begin
				fails++;
				end_of_test();
			end
		end
	endtask : scans
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, dma_on, dw_on} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		fails = 0;
		checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MODE_OFFSET, 32'h0000_0000);
		check(rd, 32'h0000_0004);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		// Every mode code, read back after each write
		exp_mode = 3'b100;
		for (int c = 0; c < 4; c++) begin
			code = 2'(c + 1);
			exp_mode = code[1] ? {1'b0, code[0], exp_mode[0]} : {1'b1, exp_mode[1], code[0]};
			apb(1'b1, MODE_OFFSET, {30'h0, code});
			apb(1'b0, MODE_OFFSET, 32'h0000_0000);
			check(rd, {29'h0, exp_mode});
		end
		// Scan make-up for each column mode, width and DMA state
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, MODE_OFFSET, {31'h0, m[2]});
			dw_on <= m[1];
			dma_on <= m[0];
			scans(3);
			chars = m[2] ? 170 : 102;
			check(32'(scan_stats[0]), 1530);
			check(32'(scan_stats[1]), chars);
			check(32'(scan_stats[2]), (m[2] ? 1530 : 1020) >> m[1]);
			check(32'(scan_stats[3]), chars >> m[1]);
			check(32'(scan_stats[4]), m[0] ? (m[1] ? 1 : 3) : 0);
		end
		end_of_test();
	end
endmodule : testbench
`default_nettype wire

/* testbench/timing_checker.sv */
// Port-level timing checks for the raster generator
`default_nettype none
module timing_checker (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              hold_request,
	input wire logic              double_width,
	input wire raster_pkg::mode_s mode,
	input wire logic              pixel_clock,
	input wire logic              char_clock,
	input wire logic              fetch_address_increment,
	input wire logic              horizontal_blank,
	input wire logic              horizontal_retrace_pulse_n,
	input wire logic              shift_register_load,
	input wire logic [7:0]        line_buffer_addr,
	input wire logic              half_scan_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	import raster_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr;            // Mode write taken now
	logic [9:0] cg, next_cg;   // Cycles since last character
	logic [9:0] hg, next_hg;   // Cycles since last half scan
	logic [9:0] lg, next_lg;   // Length of retrace so far
	logic [2:0] st, next_st;   // Settling after reset or write
	logic       cv, hv, lv;    // Gap counts are trustworthy
	logic       next_cv, next_hv, next_lv;
	logic       rn;            // Retrace level one cycle back
	assign wr = psel && penable && pwrite && (paddr == MODE_OFFSET);
	// A mode write restarts timing, so it voids every gap in flight
	always_comb begin
		next_cg = char_clock ? 10'h000 : cg + 10'h001;
		next_hg = half_scan_tick ? 10'h000 : hg + 10'h001;
		next_lg = horizontal_retrace_pulse_n ? 10'h000 : lg + 10'h001;
		next_cv = !wr && (cv || char_clock);
		next_hv = !wr && (hv || half_scan_tick);
		next_lv = !wr && (lv || (rn && !horizontal_retrace_pulse_n));
		next_st = wr ? 3'h0 : ((st == 3'h7) ? st : st + 3'h1);
	end
	// Helper registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cg, hg, lg, st, cv, hv, lv} <= '0;
			rn <= 1'b1;
		end else begin
			{cg, hg, lg, st, cv, hv, lv} <= {next_cg, next_hg, next_lg, next_st,
				next_cv, next_hv, next_lv};
			rn <= horizontal_retrace_pulse_n;
		end
	end
	chk_mode_cols: assert property (
		wr && !pwdata[MODE_HIGH_BIT] |=> mode.interlace && mode.col132 == $past(pwdata[0]))
		else $error("column write not applied");
	chk_mode_rate: assert property (
		wr && pwdata[MODE_HIGH_BIT] |=> !mode.interlace && mode.hz50 == $past(pwdata[0]))
		else $error("rate write not applied");
	chk_dot_direct: assert property (
		(mode.col132 && !double_width && st == 3'h7)[*3] |-> pixel_clock)
		else $error("direct dot clock missing");
	chk_dot_prescale: assert property (
		(!mode.col132 && !double_width && st == 3'h7)[*4] |->
		{pixel_clock, $past(pixel_clock), $past(pixel_clock, 2)} inside {3'b011, 3'b101, 3'b110})
		else $error("dot clock not two of three");
	chk_char_gap: assert property (
		char_clock && cv |-> cg == (mode.col132 ? 10'h008 : 10'h00E))
		else $error("character period wrong");
	chk_fetch_hold: assert property (
		fetch_address_increment |-> char_clock && ($past(hold_request) || $past(hold_request, 2)))
		else $error("fetch pulse without hold or off character");
	chk_blank_fall: assert property (
		$fell(horizontal_blank) |-> !char_clock)
		else $error("blank fell on a character edge");
	chk_retrace_blank: assert property (
		$fell(horizontal_retrace_pulse_n) |-> horizontal_blank)
		else $error("retrace began outside blank");
	chk_retrace_width: assert property (
		$rose(horizontal_retrace_pulse_n) && lv |-> lg >= 10'h17F && lg <= 10'h2FD)
		else $error("retrace width out of range");
	chk_half_scan: assert property (
		half_scan_tick && hv |-> hg == 10'h2FC)
		else $error("half scan period wrong");
	chk_load_char: assert property (
		!$past(double_width) |-> shift_register_load == char_clock)
		else $error("single width load off the character edge");
	chk_blank_rise: assert property (
		$rose(horizontal_blank) && st == 3'h7 |-> char_clock)
		else $error("blank rose off the character edge");
	chk_lba_half: assert property (
		half_scan_tick |=> line_buffer_addr[7] != $past(line_buffer_addr[7]))
		else $error("buffer address bit 7 did not flip at half scan");
endmodule : timing_checker
bind video_raster_timing timing_checker checker_inst (.*);
`default_nettype wire
